// >>> design/led_scan_pkg.sv
package led_scan_pkg;
  // register offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CUR_OFS     = 8'h0B;
  localparam logic [7:0] SCANF_OFS   = 8'h0C;
  localparam logic [7:0] TSEL_OFS    = 8'h0D;
  localparam logic [7:0] TRES_OFS    = 8'h0E;
  localparam logic [7:0] DOT_OFS     = 8'h10;
  localparam int         DOT_BYTES   = 14;
  // field positions
  localparam int         SOFT_RUN_BIT = 0;
  localparam int         MODE_BIT    = 1;
  localparam int         MAX_BIT     = 7;
  localparam int         DGD_BIT     = 3;
  localparam int         ROWPD_LSB   = 4;
  localparam int         COLPU_LSB   = 6;
  // reset values
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] CUR_RST     = 8'h7F;
  localparam logic [7:0] SCANF_RST   = 8'h01;
  localparam logic [7:0] TSEL_OFF    = 8'h00;
  // test select low nibble
  localparam logic [3:0] TEST_SHORT  = 4'h6;
  localparam logic [3:0] TEST_OPEN   = 4'h5;
  // timing, figures in ns and Hz
  localparam int         CLK_NS      = 50;
  localparam int         CLK_HZ      = 20_000_000;
  localparam int         SLOT_NS     = 5300;
  localparam int         GAP_NS      = 400;
  localparam int         CSDLY_NS    = 10;
  localparam int         SLOT_CYC    = SLOT_NS / CLK_NS;
  localparam int         GAP_CYC     = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int         CSDLY_CYC   = (CSDLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int         F25K_HZ     = 25_000;
  localparam int         F12K5_HZ    = 12_500;
  localparam int         F4K_HZ      = 4_000;
  localparam int         F2K_HZ      = 2_000;
  localparam int         F1K_HZ      = 1_000;
  localparam int         F500_HZ     = 500;
  localparam int         F250_HZ     = 250;
  localparam int         F25K_CYC    = CLK_HZ / F25K_HZ;
  localparam int         F12K5_CYC   = CLK_HZ / F12K5_HZ;
  localparam int         ROWS        = 7;
  localparam int         COLS        = 10;
  typedef enum logic [1:0] {
    SC_GAP  = 2'b00,
    SC_ON   = 2'b01,
    SC_IDLE = 2'b10
  } scan_state_e;
  typedef enum logic [2:0] {
    IC_IDLE = 3'b000,
    IC_DEV  = 3'b001,
    IC_REG  = 3'b010,
    IC_WR   = 3'b011,
    IC_RD   = 3'b100
  } i2c_state_e;
endpackage

// >>> design/led_matrix_scan_control.sv
// Operation
// [R1] rows enabled one at a time in order, seven or six rows per frame
// [R2] slot 5.3us, 0.4us blank between slots, columns start 0.01us after row; code starts columns one 50ns clock after row
// [R3] row output high only while selected and some dot in it lit
// [R4] one 7-bit current code drives every column sink
// [R5] top bit of current register picks 40mA or 120mA range
// [R6] host writes current register only 00-7F or AB-CA
// [R7] host keeps peak current at or below 70mA
// [R8] after test select written, per-dot results readable in result register
// [R9] host writes 00 to test select before a new selection
// [R10] host sets current code 0F before open or short test
// [R11] row pull-down and column pull-up levels come from scan register fields
// [R12] host should pick 2.2V levels for de-ghosting
// [R13] host disables de-ghost during hardware shutdown
// [R14] rising shutdown pin resets serial interface logic
// [R15] host makes no transfer as the shutdown pin rises
// [R16] registers kept through both shutdowns and interface reset
// [R17] clearing soft shutdown bit at 00h enters software shutdown
// [R18] software shutdown turns off column sinks, registers stay reachable
// [R19] shutdown pin low disables all drive, high releases it
// [R20] registers reachable during hardware shutdown
// [R21] host rewrites registers after supply brown-out before raising pin
// [R22] scan rate select sets frame rate 25kHz down to 250Hz
// [R23] pull select codes 00 2.2V, 01 1.4V, 10 0.6V, 11 rail
// [R24] scan runs by itself whenever not shut down
module led_matrix_scan_control
  import led_scan_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h50,
  parameter int         F4K_CYC   = CLK_HZ / F4K_HZ,
  parameter int         F2K_CYC   = CLK_HZ / F2K_HZ,
  parameter int         F1K_CYC   = CLK_HZ / F1K_HZ,
  parameter int         F500_CYC  = CLK_HZ / F500_HZ,
  parameter int         F250_CYC  = CLK_HZ / F250_HZ
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              hw_shutdown_pin_n,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output wire logic              sda_out,
  output wire logic              sda_oe_n,
  input  wire logic [ROWS-1:0]   fault_sense,
  output logic      [ROWS-1:0]   row_source_output,
  output logic      [COLS-1:0]   column_sink_output,
  output logic      [6:0]        global_current_code,
  output logic                   current_range_high,
  output logic      [1:0]        row_pulldown_level,
  output logic      [1:0]        column_pullup_level,
  output logic                   deghost_enable,
  output logic      [COLS-1:0]   test_column_sel,
  output logic                   test_short_mode
);
  logic        scl_q_ff, sda_q_ff, pin_q_ff, ack_ff, rw_ff, lo_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  sh_ff, ptr_ff, rd_data;
  i2c_state_e  ist_ff;
  logic [7:0]  ctrl_ff, cur_ff, scanf_ff, tsel_ff, tres_ff;
  logic [7:0]  dot_ff [DOT_BYTES];
  wire scl_rise  = scl_in & ~scl_q_ff;
  wire scl_fall  = ~scl_in & scl_q_ff;
  wire start_c   = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
  wire stop_c    = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
  wire pin_rise  = hw_shutdown_pin_n & ~pin_q_ff;
  wire byte_done = scl_fall & ~ack_ff & (bit_ff == 4'h8);
  wire wr_fire   = byte_done & (ist_ff == IC_WR);
  wire [7:0] dot_idx = ptr_ff - DOT_OFS;
  wire dot_hit   = (ptr_ff >= DOT_OFS) && (dot_idx < 8'(DOT_BYTES));
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~lo_ff;
  assign rd_data  = (ptr_ff == CTRL_OFS)  ? ctrl_ff  :
                    (ptr_ff == CUR_OFS)   ? cur_ff   :
                    (ptr_ff == SCANF_OFS) ? scanf_ff :
                    (ptr_ff == TSEL_OFS)  ? tsel_ff  :
                    (ptr_ff == TRES_OFS)  ? tres_ff  :
                    dot_hit ? dot_ff[dot_idx[3:0]] : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      pin_q_ff <= 1'b1;
    end else if (clk_en) begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
      pin_q_ff <= hw_shutdown_pin_n;
    end
  end

  // serial engine; registers left untouched by the pin-edge reset
  always_ff @(posedge clk) begin
    // [R14] pin edge clears link
    if (sys_rst || (clk_en && pin_rise)) begin
      ist_ff <= IC_IDLE;
      bit_ff <= 4'h0;
      ack_ff <= 1'b0;
      rw_ff  <= 1'b0;
      lo_ff  <= 1'b0;
      sh_ff  <= 8'h00;
      ptr_ff <= 8'h00;
    end else if (clk_en) begin
      if (start_c) begin
        ist_ff <= IC_DEV;
        bit_ff <= 4'h0;
        ack_ff <= 1'b0;
        lo_ff  <= 1'b0;
      end else if (stop_c) begin
        ist_ff <= IC_IDLE;
        lo_ff  <= 1'b0;
      end else if (ist_ff == IC_RD) begin
        if (scl_rise) begin
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff == 4'h8 && sda_in) begin
            ist_ff <= IC_IDLE;
          end
        end else if (scl_fall) begin
          if (bit_ff == 4'h9) begin
            sh_ff  <= rd_data;
            ptr_ff <= ptr_ff + 8'h01;
            bit_ff <= 4'h0;
            lo_ff  <= ~rd_data[7];
          end else if (bit_ff == 4'h8) begin
            lo_ff <= 1'b0;
          end else begin
            sh_ff <= {sh_ff[6:0], 1'b0};
            lo_ff <= ~sh_ff[6];
          end
        end
      end else if (ist_ff != IC_IDLE) begin
        if (scl_rise && !ack_ff) begin
          sh_ff  <= {sh_ff[6:0], sda_in};
          bit_ff <= bit_ff + 4'h1;
        end else if (scl_fall && ack_ff) begin
          ack_ff <= 1'b0;
          lo_ff  <= 1'b0;
          if (ist_ff == IC_DEV && rw_ff) begin
            ist_ff <= IC_RD;
            sh_ff  <= rd_data;
            ptr_ff <= ptr_ff + 8'h01;
            lo_ff  <= ~rd_data[7];
          end else if (ist_ff == IC_DEV) begin
            ist_ff <= IC_REG;
          end
        end else if (byte_done) begin
          bit_ff <= 4'h0;
          unique case (ist_ff)
            IC_DEV: begin
              if (sh_ff[7:1] == DEV_ADDR) begin
                rw_ff  <= sh_ff[0];
                ack_ff <= 1'b1;
                lo_ff  <= 1'b1;
              end else begin
                ist_ff <= IC_IDLE;
              end
            end
            IC_REG: begin
              ptr_ff <= sh_ff;
              ist_ff <= IC_WR;
              ack_ff <= 1'b1;
              lo_ff  <= 1'b1;
            end
            default: begin
              ptr_ff <= ptr_ff + 8'h01;
              ack_ff <= 1'b1;
              lo_ff  <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // [R16] [R20] only sys_rst resets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff  <= CTRL_RST;
      cur_ff   <= CUR_RST;
      scanf_ff <= SCANF_RST;
      tsel_ff  <= TSEL_OFF;
    end else if (clk_en && wr_fire) begin
      if (ptr_ff == CTRL_OFS) ctrl_ff <= sh_ff;
      if (ptr_ff == CUR_OFS) cur_ff <= sh_ff;
      if (ptr_ff == SCANF_OFS) scanf_ff <= sh_ff;
      if (ptr_ff == TSEL_OFS) tsel_ff <= sh_ff;
    end
  end

  for (genvar g = 0; g < DOT_BYTES; g++) begin : g_dot
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        dot_ff[g] <= 8'h00;
      end else if (clk_en && wr_fire && dot_hit && dot_idx[3:0] == 4'(g)) begin
        dot_ff[g] <= sh_ff;
      end
    end
  end

  wire [3:0] tcol     = tsel_ff[7:4];
  wire       tcol_ok  = (tcol != 4'h0) && (tcol <= 4'(COLS));
  wire       t_short  = tcol_ok && (tsel_ff[3:0] == TEST_SHORT);
  wire       t_open   = tcol_ok && (tsel_ff[3:0] == TEST_OPEN);
  wire       t_active = t_short | t_open;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tres_ff         <= 8'h00;
      test_column_sel <= '0;
      test_short_mode <= 1'b0;
    end else if (clk_en) begin
      // [R8] result follows sensed faults
      tres_ff         <= t_active ? {1'b0, fault_sense} : 8'h00;
      test_column_sel <= t_active ? COLS'(1) << (tcol - 4'h1) : '0;
      test_short_mode <= t_short;
    end
  end

  scan_state_e st_ff;
  logic [16:0] fcnt_ff, cnt_ff, frame_len;
  logic [2:0]  row_ff;
  wire         hw_off  = ~hw_shutdown_pin_n;
  // [R17] bit low is software shutdown
  wire         sw_off  = ~ctrl_ff[SOFT_RUN_BIT];
  wire [2:0]   last_row = ctrl_ff[MODE_BIT] ? 3'd5 : 3'd6;
  wire [COLS-1:0] row_dots = {dot_ff[{row_ff, 1'b1}][1:0], dot_ff[{row_ff, 1'b0}]};

  // [R22] frame length per rate code
  assign frame_len = (scanf_ff[2:0] == 3'b010) ? 17'(F12K5_CYC) :
                     (scanf_ff[2:0] == 3'b011) ? 17'(F4K_CYC)   :
                     (scanf_ff[2:0] == 3'b100) ? 17'(F2K_CYC)   :
                     (scanf_ff[2:0] == 3'b101) ? 17'(F1K_CYC)   :
                     (scanf_ff[2:0] == 3'b110) ? 17'(F500_CYC)  :
                     (scanf_ff[2:0] == 3'b111) ? 17'(F250_CYC)  :
                     17'(F25K_CYC);
  wire frame_end = (fcnt_ff >= frame_len - 17'd1);

  always_ff @(posedge clk) begin
    // [R24] free-running unless the shutdown pin is low
    if (sys_rst || (clk_en && hw_off)) begin
      st_ff   <= SC_GAP;
      fcnt_ff <= '0;
      cnt_ff  <= '0;
      row_ff  <= 3'd0;
    end else if (clk_en) begin
      fcnt_ff <= frame_end ? 17'd0 : fcnt_ff + 17'd1;
      cnt_ff  <= cnt_ff + 17'd1;
      unique case (st_ff)
        // [R2] blanking gap then slot
        SC_GAP: if (cnt_ff == 17'(GAP_CYC - 1)) begin
          st_ff  <= SC_ON;
          cnt_ff <= '0;
        end
        // [R1] next row in order
        SC_ON: if (cnt_ff == 17'(SLOT_CYC - 1)) begin
          cnt_ff <= '0;
          if (row_ff == last_row) begin
            st_ff <= SC_IDLE;
          end else begin
            st_ff  <= SC_GAP;
            row_ff <= row_ff + 3'd1;
          end
        end
        SC_IDLE: if (frame_end) begin
          st_ff  <= SC_GAP;
          cnt_ff <= '0;
          row_ff <= 3'd0;
        end
        default: st_ff <= SC_GAP;
      endcase
    end
  end

  wire on_now  = (st_ff == SC_ON) && (row_dots != '0);
  wire cs_now  = on_now && (cnt_ff >= 17'(CSDLY_CYC)) && !sw_off;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      row_source_output   <= '0;
      column_sink_output  <= '0;
      global_current_code <= 7'h00;
      current_range_high  <= 1'b0;
      row_pulldown_level  <= 2'b00;
      column_pullup_level <= 2'b00;
      deghost_enable      <= 1'b0;
    end else if (clk_en) begin
      // [R3] [R19] row high only when lit
      row_source_output   <= (on_now && !hw_off) ? ROWS'(1) << row_ff : '0;
      // [R18] [R2] sinks after delay
      column_sink_output  <= (cs_now && !hw_off) ? row_dots : '0;
      // [R4] shared code
      global_current_code <= cur_ff[6:0];
      // [R5] range bit
      current_range_high  <= cur_ff[MAX_BIT];
      // [R11] [R23] pull level codes
      row_pulldown_level  <= scanf_ff[ROWPD_LSB +: 2];
      column_pullup_level <= scanf_ff[COLPU_LSB +: 2];
      deghost_enable      <= ~scanf_ff[DGD_BIT] & ~hw_off;
    end
  end
endmodule

// >>> verification/led_matrix_scan_control_assertions.sv
module led_matrix_scan_control_assertions
  import led_scan_pkg::*;
(
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            hw_shutdown_pin_n,
  input wire logic            sda_oe_n,
  input wire logic [ROWS-1:0] row_source_output,
  input wire logic [COLS-1:0] column_sink_output,
  input wire logic [6:0]      global_current_code,
  input wire logic            deghost_enable,
  input wire logic [COLS-1:0] test_column_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ROWS-1:0] prev_ff;
  logic [7:0]      run_ff;
  wire logic       row_on = row_source_output != '0;
  // cycles the current row pattern has held
  always_ff @(posedge clk) begin
    prev_ff <= row_source_output;
    run_ff  <= sys_rst ? 8'h00 : (row_source_output == prev_ff) ? run_ff + 8'h01 : 8'h01;
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RST_OUT: assert property (disable iff (1'b0) sys_rst |=> !row_on &&
    column_sink_output == '0 && global_current_code == 7'h00 && sda_oe_n)
    else $error("outputs not cleared by reset");
  AST_ROW_ONEHOT: assert property ($onehot0(row_source_output))
    else $error("more than one row driven");
  AST_SLOT_LEN: assert property (prev_ff != '0 && row_source_output != prev_ff &&
    hw_shutdown_pin_n && $past(hw_shutdown_pin_n) |-> run_ff == 8'(SLOT_CYC))
    else $error("row slot length wrong");
  AST_GAP: assert property ($past(row_on) && $changed(row_source_output) |->
    (!row_on) [*8]) else $error("blanking gap too short");
  AST_COL_LAG: assert property (!$past(row_on) && row_on |-> column_sink_output == '0)
    else $error("columns on with row turn-on");
  AST_COL_ROW: assert property (column_sink_output != '0 |-> row_on)
    else $error("columns sinking with no row");
  AST_HW_OFF: assert property (!hw_shutdown_pin_n |=> !row_on &&
    column_sink_output == '0 && !deghost_enable) else $error("drive during shutdown pin low");
  AST_TEST_SEL: assert property ($onehot0(test_column_sel))
    else $error("several test columns selected");
endmodule

// >>> verification/led_matrix_model.sv
module led_matrix_model
  import led_scan_pkg::*;
(
  input  wire logic [COLS-1:0] test_column_sel,
  input  wire logic            test_short_mode,
  output logic      [ROWS-1:0] fault_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    fault_sense = '0;
    for (int c = 0; c < COLS; c++)
      if (test_column_sel[c])
        fault_sense = test_short_mode ? 7'h01 << (c % ROWS) : 7'h40 >> (c % ROWS);
  end
endmodule

// >>> verification/tb_led_matrix_scan_control.sv
module tb_led_matrix_scan_control;
  import led_scan_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk, sys_rst, clk_en, hw_n, scl, sdh, seen6;
  wire logic       sda_out, sda_oe_n, tshort, rng, dg;
  wire logic [6:0] flt, rows, code;
  wire logic [9:0] cols, tcol;
  wire logic [1:0] pd, pu;
  wire logic       sda = sdh & sda_oe_n;
  int              bad_count, compares;
  logic [7:0]      r;

  led_matrix_scan_control #(.F4K_CYC(900), .F2K_CYC(1000), .F1K_CYC(1100), .F500_CYC(1200),
    .F250_CYC(1300)) dut (.clk, .sys_rst, .clk_en, .hw_shutdown_pin_n(hw_n), .scl_in(scl),
    .sda_in(sda), .sda_out, .sda_oe_n, .fault_sense(flt), .row_source_output(rows),
    .column_sink_output(cols), .global_current_code(code), .current_range_high(rng),
    .row_pulldown_level(pd), .column_pullup_level(pu), .deghost_enable(dg),
    .test_column_sel(tcol), .test_short_mode(tshort));
  led_matrix_model pm (.test_column_sel(tcol), .test_short_mode(tshort), .fault_sense(flt));

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (rows[6] === 1'b1) seen6 <= 1'b1;

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic drv(logic c, logic d);
    @(posedge clk);
    scl <= c;
    sdh <= d;
    repeat (3) @(posedge clk);
  endtask
  task automatic start();
    drv(0, 1);
    drv(1, 1);
    drv(1, 0);
    drv(0, 0);
  endtask
  task automatic stop();
    drv(0, 0);
    drv(1, 0);
    drv(1, 1);
  endtask
  // one byte plus the ninth bit, e is the expected ninth-bit level
  task automatic xb(logic [7:0] w, logic e, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      drv(0, w[i]);
      drv(1, w[i]);
      q[i] = sda;
    end
    drv(0, 1);
    drv(1, 1);
    chk("ack", e, sda);
    drv(0, 1);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    start();
    xb(8'hA0, 0, r);
    xb(a, 0, r);
    xb(d, 0, r);
    stop();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    start();
    xb(8'hA0, 0, r);
    xb(a, 0, r);
    start();
    xb(8'hA1, 0, r);
    xb(8'hFF, 1, r);
    stop();
    chk("rdata", e, r);
  endtask
  task automatic pin(logic v);
    hw_n <= v;
    repeat (3) @(posedge clk);
  endtask
  task automatic rise0(output int t);
    for (int n = 0; n < 2000 && rows[0] !== 1'b0; n++) @(posedge clk);
    for (int n = 0; n < 2000 && rows[0] !== 1'b1; n++) @(posedge clk);
    t = int'($time / CLK_NS);
  endtask
  task automatic frame(int e, logic e6, logic [9:0] ec);
    int t0, t1;
    rise0(t0);
    seen6 = 0;
    rise0(t1);
    chk("frame", e, t1 - t0);
    chk("row6", e6, seen6);
    repeat (3) @(posedge clk);
    chk("cols", ec, cols);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    sys_rst = 1;
    clk_en = 1;
    hw_n = 1;
    scl = 1;
    sdh = 1;
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    repeat (2) @(posedge clk);
    chk("code", 7'h7F, code);
    rd(CUR_OFS, CUR_RST);
    rd(SCANF_OFS, SCANF_RST);
    rd(8'h05, 8'h00);
    wr(CUR_OFS, 8'hAB);
    chk("code", 7'h2B, code);
    chk("range", 1, rng);
    wr(CUR_OFS, 8'h0F);
    for (int c = 1; c <= COLS; c++)
      for (int m = 5; m <= 6; m++) begin
        wr(TSEL_OFS, {c[3:0], m[3:0]});
        chk("tcol", 1 << (c - 1), tcol);
        chk("tshort", m == 6, tshort);
        rd(TRES_OFS, m == 6 ? 8'h01 << ((c - 1) % 7) : 8'h40 >> ((c - 1) % 7));
        wr(TSEL_OFS, TSEL_OFF);
      end
    rd(TRES_OFS, 8'h00);
    pin(0);
    chk("dg", 0, dg);
    wr(DOT_OFS, 8'h81);
    wr(DOT_OFS + 1, 8'h02);
    wr(DOT_OFS + 12, 8'h01);
    pin(1);
    frame(F25K_CYC, 1, 10'h000);
    pin(0);
    wr(CTRL_OFS, 8'h03);
    wr(SCANF_OFS, 8'hD7);
    pin(1);
    chk("pd", 1, pd);
    chk("pu", 3, pu);
    chk("dg", 1, dg);
    frame(1300, 0, 10'h281);
    pin(0);
    wr(CTRL_OFS, 8'h00);
    wr(SCANF_OFS, 8'h28);
    pin(1);
    chk("pd", 2, pd);
    chk("dg", 0, dg);
    frame(F25K_CYC, 1, 10'h000);
    pin(0);
    start();
    xb(8'hA0, 0, r);
    xb(CUR_OFS, 0, r);
    pin(1);
    xb(8'h33, 1, r);
    stop();
    rd(CUR_OFS, 8'h0F);
    wr(SCANF_OFS, 8'h01);
    chk("pd", 0, pd);
    chk("pu", 0, pu);
    chk("dg", 1, dg);
    final_report();
  end

  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule

bind led_matrix_scan_control led_matrix_scan_control_assertions chk_i (.clk, .sys_rst,
  .hw_shutdown_pin_n, .sda_oe_n, .row_source_output, .column_sink_output,
  .global_current_code, .deghost_enable, .test_column_sel);
